// >>> pseq_pkg.sv
// shared constants and types for the program sequencer
package pseq_pkg;
    localparam int PC_W = 12;                    // program counter width
    localparam int STACK_DEPTH = 6;              // return-address levels
    localparam int ADDR_W = 8;                   // register port address width
    localparam int INT_N = 3;                    // interrupt sources

    // register offsets on the plain register port
    localparam logic [7:0] REG_PCL = 8'h00;      // program_counter_low_byte
    localparam logic [7:0] REG_STATUS = 8'h01;   // sequencer status

    // values after reset and fixed vectors
    localparam logic [11:0] PC_RST = 12'h000;    // reset vector
    localparam logic [11:0] VEC_EXT = 12'h004;   // external interrupt
    localparam logic [11:0] VEC_TMR0 = 12'h008;  // timer/event counter 0
    localparam logic [11:0] VEC_TMR1 = 12'h00c;  // timer/event counter 1
    localparam logic [2:0] SIDX_EMPTY = 3'h0;    // stack index at top
    localparam logic [2:0] SIDX_FULL = 3'h6;     // all six levels used
    localparam logic [2:0] PHASES_LAST = 3'h3;   // four phases, 0..3

    // the four internal phases of one instruction cycle
    typedef enum logic [1:0] {
        PH_FETCH  = 2'b00,
        PH_DECODE = 2'b01,
        PH_EXEC   = 2'b10,
        PH_WB     = 2'b11
    } pseq_phase_type;

    // flow operation reported by the executing instruction
    typedef enum logic [2:0] {
        OP_NEXT   = 3'b000,
        OP_SKIP   = 3'b001,
        OP_BRANCH = 3'b010,
        OP_CALL   = 3'b011,
        OP_RET    = 3'b100,
        OP_RETURN_FROM_INTERRUPT   = 3'b101
    } pseq_op_type;
endpackage

// >>> pseq_phase.sv
// four-phase generator and fetch phase clock output
module pseq_phase
(
    input  wire logic                     clk_sys,
    input  wire logic                     nrst,
    input  wire logic                     rc_osc_mode,
    output pseq_pkg::pseq_phase_type      phase,
    output logic                          fetch_phase_clock,
    output logic                          second_oscillator_pin,
    output logic                          second_oscillator_pin_oe
);
    import pseq_pkg::*;

    // all state of the generator
    typedef struct packed {
        pseq_phase_type ph;      // current phase
        logic           t1;      // high in fetch phase only
        logic           pin;     // pin copy, gated by rc mode
        logic           oe;      // pin driven only in rc mode
    } pseq_ph_state_type;

    pseq_ph_state_type s;        // registered state
    pseq_ph_state_type next_s;   // next state

    // phases walk 0..3 and wrap; clock out is decoded ahead of time
    // so the pin comes straight from a flip-flop, free of glitches
    always_comb
    begin
        next_s = s;
        unique case (s.ph)
            PH_FETCH:  next_s.ph = PH_DECODE;
            PH_DECODE: next_s.ph = PH_EXEC;
            PH_EXEC:   next_s.ph = PH_WB;
            PH_WB:     next_s.ph = PH_FETCH;
        endcase
        next_s.t1 = (next_s.ph == PH_FETCH);
        next_s.pin = next_s.t1 && rc_osc_mode;
        next_s.oe = rc_osc_mode;
    end

    // synchronous reset parks the generator just before a fetch
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            s <= '{ph: PH_WB, t1: 1'b0, pin: 1'b0, oe: 1'b0};
        end
        else
        begin
            s <= next_s;
        end
    end

    assign phase = s.ph;
    assign fetch_phase_clock = s.t1;
    assign second_oscillator_pin = s.pin;
    assign second_oscillator_pin_oe = s.oe;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    sequence s_low_three;
        (!second_oscillator_pin) [*3];
    endsequence

    a_phase_wrap: assert property (phase == PH_WB |=> phase == PH_FETCH)
        else $error("phase did not wrap to fetch");
    a_osc_duty: assert property (
        disable iff (!nrst || !rc_osc_mode)
        $rose(second_oscillator_pin) |=> s_low_three ##1 second_oscillator_pin)
        else $error("fetch clock pin not one high in four");
endmodule

// >>> pseq_top.sv
// program sequencer: counter, skip/branch control, return stack
//
// Decided for this implementation: the register addresses and the strobed register port.
import pseq_pkg::*;

// Behaviour
// - four phases make one instruction cycle
// - counter advances entering fetch phase only
// - fetch overlaps execute; transfers add a cycle
// - rc mode: pin shows fetch clock 1:3
// - counter steps by one otherwise
// - only low byte is software visible
// - true skip discards fetched instruction, dummy
// - low byte write keeps page, dummy
// - jump, call, interrupt load full address
// - six hidden levels, index not accessible
// - call/interrupt push, returns pop counter
// - reset empties the stack
// - full stack holds interrupt flag pending
// - call on full stack still overflows
// - fixed vectors 000, 004, 008, 00c
module pseq_top
(
    input  wire logic                     clk_sys,
    input  wire logic                     nrst,
    input  wire logic                     rc_osc_mode,
    input  wire logic [pseq_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [7:0]               reg_wdata,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    output logic [7:0]                    reg_rdata,
    input  wire logic                     exec_valid,
    input  wire pseq_pkg::pseq_op_type    exec_op,
    input  wire logic                     skip_cond,
    input  wire logic [pseq_pkg::PC_W-1:0] exec_target,
    input  wire logic [pseq_pkg::INT_N-1:0] int_req,
    input  wire logic [pseq_pkg::INT_N-1:0] int_enable,
    input  wire logic                     int_master_en,
    output logic [pseq_pkg::INT_N-1:0]    int_ack,
    output logic                          int_return,
    output logic [pseq_pkg::PC_W-1:0]     prog_addr,
    output logic                          prog_fetch,
    output logic                          exec_dummy,
    output pseq_pkg::pseq_phase_type      phase,
    output logic                          fetch_phase_clock,
    output logic                          second_oscillator_pin,
    output logic                          second_oscillator_pin_oe
);
    import pseq_pkg::*;

    // all state of the sequencer
    typedef struct packed {
        logic [11:0]       pc;       // address of instruction in flight
        logic [5:0][11:0]  stack;    // return addresses
        logic [2:0]        sidx;     // levels in use
        logic              pcl_pend; // low byte write waiting
        logic [7:0]        pcl_val;  // written low byte
        logic              dummy;    // current cycle is discarded
        logic [2:0]        flags;    // recorded interrupt requests
        logic [2:0]        ack;      // acknowledge pulse, one-hot
        logic              return_from_interrupt;     // return from interrupt pulse
        logic [7:0]        rdata;    // register read data
        logic              fetch;    // fetch strobe
    } pseq_state_type;

    pseq_state_type s;           // registered state
    pseq_state_type next_s;      // next state

    pseq_phase_type ph;          // phase from the generator
    logic           run;         // live instruction reports at boundary
    logic           full;        // every level occupied
    logic           xfer;        // counter loaded this boundary
    logic           pcl_sel;     // low byte write applied this boundary
    logic [2:0]     push_idx;    // slot written by a push
    logic [2:0]     pop_idx;     // slot read by a pop
    logic [2:0]     live;        // enabled, recorded requests
    logic [2:0]     grant;       // highest-priority live request
    logic [11:0]    vec;         // vector of the granted request

    // phase generator and fetch clock pin
    pseq_phase u_phase
    (
        .clk_sys                  (clk_sys),
        .nrst                     (nrst),
        .rc_osc_mode              (rc_osc_mode),
        .phase                    (ph),
        .fetch_phase_clock        (fetch_phase_clock),
        .second_oscillator_pin    (second_oscillator_pin),
        .second_oscillator_pin_oe (second_oscillator_pin_oe)
    );

    // fixed priority: external, then timer 0, then timer 1
    always_comb
    begin
        live = s.flags & int_enable & {3{int_master_en}};
        grant = 3'b000;
        vec = VEC_EXT;
        if (live[0])
        begin
            grant = 3'b001;
            vec = VEC_EXT;
        end
        else if (live[1])
        begin
            grant = 3'b010;
            vec = VEC_TMR0;
        end
        else if (live[2])
        begin
            grant = 3'b100;
            vec = VEC_TMR1;
        end
    end

    // next-state logic; all flow decisions fall on the last phase
    // so the new address is ready exactly as fetch begins
    always_comb
    begin
        next_s = s;
        next_s.ack = 3'b000;
        next_s.return_from_interrupt = 1'b0;
        next_s.fetch = 1'b0;
        next_s.rdata = 8'h00;
        xfer = 1'b0;
        pcl_sel = 1'b0;
        full = (s.sidx == SIDX_FULL);
        // a discarded instruction must not steer the flow
        run = (ph == PH_WB) && exec_valid && !s.dummy;
        // overflow rewrites the deepest slot, index stays full
        push_idx = full ? (SIDX_FULL - 3'h1) : s.sidx;
        pop_idx = (s.sidx == SIDX_EMPTY) ? SIDX_EMPTY
                                         : (s.sidx - 3'h1);

        // requests are recorded at once; a new one beats the clear
        next_s.flags = s.flags | int_req;

        if (ph == PH_WB)
        begin
            next_s.fetch = 1'b1;
            next_s.dummy = 1'b0;
            next_s.pc = s.pc + 12'h001;
            if (run && exec_op != OP_NEXT)
            begin
                unique case (exec_op)
                    OP_SKIP:
                    begin
                        // fetched word is thrown away: net step of two
                        next_s.dummy = skip_cond;
                    end
                    OP_BRANCH:
                    begin
                        next_s.pc = exec_target;
                        next_s.dummy = 1'b1;
                        xfer = 1'b1;
                    end
                    OP_CALL:
                    begin
                        // performed even when full; flow then undefined
                        next_s.stack[push_idx] = s.pc;
                        if (!full)
                        begin
                            next_s.sidx = s.sidx + 3'h1;
                        end
                        next_s.pc = exec_target;
                        next_s.dummy = 1'b1;
                        xfer = 1'b1;
                    end
                    OP_RET, OP_RETURN_FROM_INTERRUPT:
                    begin
                        next_s.pc = s.stack[pop_idx];
                        if (s.sidx != SIDX_EMPTY)
                        begin
                            next_s.sidx = s.sidx - 3'h1;
                        end
                        next_s.return_from_interrupt = (exec_op == OP_RETURN_FROM_INTERRUPT);
                        next_s.dummy = 1'b1;
                        xfer = 1'b1;
                    end
                    default:
                    begin
                        next_s.dummy = 1'b0;             // illegal code
                    end
                endcase
            end
            else if (s.pcl_pend)
            begin
                // only the low byte moves: jump stays in this page
                next_s.pc = {s.pc[11:8], s.pcl_val};
                next_s.pcl_pend = 1'b0;
                next_s.dummy = 1'b1;
                pcl_sel = 1'b1;
                xfer = 1'b1;
            end
            else if (grant != 3'b000 && !full)
            begin
                // a full stack holds the acknowledge off until a return
                next_s.stack[push_idx] = s.pc;
                next_s.sidx = s.sidx + 3'h1;
                next_s.pc = vec;
                next_s.ack = grant;
                next_s.flags = (s.flags & ~grant) | int_req;
                next_s.dummy = 1'b1;
                xfer = 1'b1;
            end
        end

        // register port; the stack and its index have no address
        if (reg_wr && reg_addr == REG_PCL)
        begin
            next_s.pcl_pend = 1'b1;
            next_s.pcl_val = reg_wdata;
        end
        if (reg_rd)
        begin
            unique case (reg_addr)
                REG_PCL:    next_s.rdata = s.pc[7:0];
                REG_STATUS: next_s.rdata = {ph, s.dummy, s.flags,
                                            s.pcl_pend, 1'b0};
                default:    next_s.rdata = 8'h00;        // unmapped
            endcase
        end
    end

    // state register; reset points at vector zero with an empty stack
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            s <= '0;
            s.pc <= PC_RST;
            s.sidx <= SIDX_EMPTY;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign reg_rdata = s.rdata;
    assign int_ack = s.ack;
    assign int_return = s.return_from_interrupt;
    assign prog_addr = s.pc;
    assign prog_fetch = s.fetch;
    assign exec_dummy = s.dummy;
    assign phase = ph;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    sequence s_skip_taken;
        ph == PH_WB && run && exec_op == OP_SKIP && skip_cond;
    endsequence

    sequence s_dummy_cycle;
        exec_dummy [*4];
    endsequence

    a_pc_hold: assert property (ph != PH_WB |=> $stable(prog_addr))
        else $error("counter moved outside the fetch boundary");
    a_pc_step: assert property (
        ph == PH_WB && !xfer |=> prog_addr == $past(prog_addr) + 12'h001)
        else $error("counter did not step by one");
    a_skip_dummy: assert property (
        s_skip_taken |=> s_dummy_cycle)
        else $error("true skip did not give a dummy cycle");
    a_pcl_page: assert property (
        pcl_sel |=> prog_addr[11:8] == $past(prog_addr[11:8])
                    && exec_dummy)
        else $error("low byte load left the page or no dummy");
    a_branch_load: assert property (
        ph == PH_WB && run && exec_op == OP_BRANCH
        |=> prog_addr == $past(exec_target) ##4 prog_fetch == 1'b1)
        else $error("branch target not loaded");
    a_call_push: assert property (
        ph == PH_WB && run && exec_op == OP_CALL && !full
        |=> s.sidx == $past(s.sidx) + 3'h1
            && s.stack[$past(s.sidx)] == $past(prog_addr))
        else $error("call did not push the return address");
    a_full_block: assert property (full && ph == PH_WB |=> int_ack == 3'b000)
        else $error("interrupt acknowledged on a full stack");
    a_read_timing: assert property (
        reg_rd && reg_addr == REG_PCL |=> reg_rdata == $past(prog_addr[7:0]))
        else $error("low byte read data wrong");
endmodule

// >>> pseq_prog_model.sv
// program memory and interrupt source model facing the sequencer
module pseq_prog_model
    import pseq_pkg::*;
(
    input  wire logic                clk_sys,
    input  wire logic                nrst,
    input  wire logic [PC_W-1:0]     prog_addr,
    input  wire logic                prog_fetch,
    input  wire logic [INT_N-1:0]    req_cmd,
    output logic                     exec_valid,
    output pseq_op_type              exec_op,
    output logic                     skip_cond,
    output logic [PC_W-1:0]          exec_target,
    output logic [INT_N-1:0]         int_req
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] rom [0:4095];       // {op, skip, target}, filled by bench
    logic [15:0] fetched;            // word read at the last fetch
    logic [15:0] exe;                // word now being executed

    assign exec_op = pseq_op_type'(exe[15:13]);
    assign skip_cond = exe[12];
    assign exec_target = exe[11:0];

    // fetch of the next word overlaps execution of the current one
    // the op is offered in every phase, so any early take would show
    always @(posedge clk_sys)
    begin
        int_req <= req_cmd;          // pulses only: a held line would re-arm
        if (!nrst)
        begin
            fetched <= rom[0];       // reset address is fetched in reset
            exe <= 16'h0000;
            exec_valid <= 1'b0;
        end
        else
        begin
            exec_valid <= 1'b1;
            if (prog_fetch === 1'b1)
            begin
                exe <= fetched;
                fetched <= rom[prog_addr];
            end
        end
    end
endmodule

// >>> test_program_sequencer_with_call_stack.sv
// self-checking bench for the program sequencer
module test_program_sequencer_with_call_stack;
    import pseq_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic nrst, rc_osc_mode, reg_wr, reg_rd, int_master_en;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, lo;
    logic [2:0] int_enable, req_cmd, int_ack, int_req;
    logic exec_valid, skip_cond, int_return, prog_fetch, exec_dummy;
    logic fetch_phase_clock, second_oscillator_pin, second_oscillator_pin_oe;
    logic [11:0] exec_target, prog_addr;
    pseq_op_type exec_op;
    pseq_phase_type phase;
    logic [15:0] rnd;                // lfsr state
    logic [12:0] exp_f [$];          // {dummy, address} per fetch
    logic [7:0] exp_rd [$];
    logic [2:0] exp_ack [$];
    int err_total, total_checks, cyc, last, ret_cnt, n;
    bit have_last, rd_seen, mode_d;
    logic [12:0] seq1 [0:29] = '{13'h0001, 13'h0002, 13'h1120, 13'h0121,
        13'h1122, 13'h0123, 13'h1300, 13'h0301, 13'h1123, 13'h0124,
        13'h1410, 13'h0411, 13'h1420, 13'h0421, 13'h1430, 13'h0431,
        13'h1440, 13'h0441, 13'h1450, 13'h0451, 13'h1460, 13'h0461,
        13'h0462, 13'h1451, 13'h1008, 13'h0009, 13'h000a, 13'h1451,
        13'h0452, 13'h0453};

    always #20 clk_sys = ~clk_sys;

    pseq_top dut (.clk_sys(clk_sys), .nrst(nrst), .rc_osc_mode(rc_osc_mode),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .exec_valid(exec_valid),
        .exec_op(exec_op), .skip_cond(skip_cond), .exec_target(exec_target),
        .int_req(int_req), .int_enable(int_enable),
        .int_master_en(int_master_en), .int_ack(int_ack),
        .int_return(int_return), .prog_addr(prog_addr),
        .prog_fetch(prog_fetch), .exec_dummy(exec_dummy), .phase(phase),
        .fetch_phase_clock(fetch_phase_clock),
        .second_oscillator_pin(second_oscillator_pin),
        .second_oscillator_pin_oe(second_oscillator_pin_oe));

    pseq_prog_model far (.clk_sys(clk_sys), .nrst(nrst),
        .prog_addr(prog_addr), .prog_fetch(prog_fetch), .req_cmd(req_cmd),
        .exec_valid(exec_valid), .exec_op(exec_op), .skip_cond(skip_cond),
        .exec_target(exec_target), .int_req(int_req));

    // one compare task per width of result
    task automatic chk13(input logic [12:0] g, input logic [12:0] e);
        total_checks++;
        if (g !== e)
        begin
            err_total++;
            $display("ERROR t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        chk13({5'h00, g}, {5'h00, e});
    endtask
    task automatic chk1(input logic g, input logic e);
        chk13({12'h000, g}, {12'h000, e});
    endtask

    task automatic tally_and_finish();
        if (err_total == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic set_op(input logic [11:0] a, input pseq_op_type op,
                          input logic s, input logic [11:0] t);
        far.rom[a] = {op, s, t};
    endtask

    // wait, bounded, until the sequencer fetches a given address
    task automatic wait_fetch(input logic [11:0] a);
        int k;
        k = 0;
        do
        begin
            @(posedge clk_sys);
            k++;
        end
        while (!(prog_fetch === 1'b1 && prog_addr === a) && k < 400);
        if (k >= 400)
            err_total++;
    endtask

    task automatic reg_read(input logic [7:0] a, input logic [7:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        exp_rd.push_back(e);
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(posedge clk_sys);
    endtask

    // watcher: outputs sampled at each edge, before this edge's updates
    always @(posedge clk_sys)
    begin
        cyc++;
        if (!nrst)
        begin
            have_last = 0;
            mode_d = 0;
        end
        else
        begin
            chk1(fetch_phase_clock, phase === PH_FETCH);
            chk1(second_oscillator_pin, fetch_phase_clock & mode_d);
            chk1(second_oscillator_pin_oe, mode_d);
            mode_d = rc_osc_mode;
            if (rd_seen)
                chk8(reg_rdata, exp_rd.pop_front());
            rd_seen = (reg_rd === 1'b1);
            if (int_ack !== 3'h0)
                chk13({10'h000, int_ack}, {10'h000, exp_ack.pop_front()});
            if (int_return === 1'b1)
                ret_cnt++;
            if (prog_fetch === 1'b1)
            begin
                chk13({exec_dummy, prog_addr}, exp_f.pop_front());
                if (have_last)
                    chk8(8'(cyc - last), 8'h04);
                last = cyc;
                have_last = 1;
            end
        end
    end

    // watchdog: the whole run needs well under a thousand cycles
    initial
    begin
        repeat (4000) @(posedge clk_sys);
        err_total++;
        tally_and_finish();
    end

    initial
    begin
        {nrst, reg_wr, reg_rd, req_cmd, reg_addr, reg_wdata} = '0;
        {rc_osc_mode, int_master_en, int_enable} = 5'h1f;
        {err_total, total_checks, cyc, last, ret_cnt} = '0;
        rnd = 16'he876;
        for (int i = 0; i < 4096; i++)
            far.rom[i] = 16'h0000;
        set_op(12'h001, OP_BRANCH, 1'b0, 12'h120);
        set_op(12'h120, OP_SKIP, 1'b1, 12'h000);
        set_op(12'h122, OP_CALL, 1'b0, 12'h300);
        set_op(12'h300, OP_RET, 1'b0, 12'h000);
        set_op(12'h123, OP_CALL, 1'b0, 12'h410);
        for (int k = 1; k < 6; k++)
            set_op(12'(12'h400 + k * 16), OP_CALL, 1'b0,
                   12'(12'h410 + k * 16));
        set_op(12'h461, OP_RET, 1'b0, 12'h000);
        set_op(12'h009, OP_RETURN_FROM_INTERRUPT, 1'b0, 12'h000);
        for (int k = 0; k < 16; k++)
            set_op(12'(12'h470 + k), OP_BRANCH, 1'b0, 12'h45b);
        set_op(12'h45b, OP_CALL, 1'b0, 12'h500);
        set_op(12'h500, OP_CALL, 1'b0, 12'h600);
        foreach (seq1[i])
            exp_f.push_back(seq1[i]);
        repeat (5) @(posedge clk_sys);
        nrst <= 1'b1;
        // request while all six levels are in use: held until a return
        wait_fetch(12'h460);
        req_cmd <= 3'b010;
        exp_ack.push_back(3'b010);
        @(posedge clk_sys);
        req_cmd <= 3'b000;
        // low byte write with a random in-page target
        wait_fetch(12'h453);
        rnd = lfsr(rnd);
        lo = {5'b01110, rnd[2:0]};
        reg_addr <= REG_PCL;
        reg_wdata <= lo;
        reg_wr <= 1'b1;
        exp_f.push_back({5'h14, lo});
        exp_f.push_back({5'h04, 8'(lo + 8'h01)});
        foreach (seq1[i])
            if (i < 6)
                exp_f.push_back(i[0] ? {1'b0, 12'h45c + 12'(i/2 * 'h52)} : 13'h0);
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        exp_f = exp_f[0:$-6];
        exp_f.push_back(13'h145b);
        exp_f.push_back(13'h045c);
        exp_f.push_back(13'h1500);
        exp_f.push_back(13'h0501);
        exp_f.push_back(13'h1600);
        exp_f.push_back(13'h0601);
        wait_fetch({4'h4, 8'(lo + 8'h01)});
        reg_read(REG_PCL, 8'(lo + 8'h01));
        reg_read(8'h7f, 8'h00);
        // second reset in mid-run, overflowed stack must come back empty
        wait_fetch(12'h601);
        nrst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        nrst <= 1'b1;
        exp_f.push_back(13'h0001);
        wait_fetch(12'h001);
        req_cmd <= 3'b001;
        exp_ack.push_back(3'b001);
        exp_f.push_back(13'h1004);
        exp_f.push_back(13'h0005);
        // then: masked timer 1 request, held past a return from interrupt
        exp_f.push_back(13'h0006);
        exp_f.push_back(13'h0007);
        exp_f.push_back(13'h0008);
        exp_f.push_back(13'h0009);
        exp_f.push_back(13'h000a);
        exp_f.push_back(13'h1001);
        exp_f.push_back(13'h100c);
        exp_f.push_back(13'h000d);
        @(posedge clk_sys);
        req_cmd <= 3'b000;
        wait_fetch(12'h005);
        int_master_en <= 1'b0;
        req_cmd <= 3'b100;
        @(posedge clk_sys);
        req_cmd <= 3'b000;
        wait_fetch(12'h008);
        int_master_en <= 1'b1;
        int_enable <= 3'b011;
        wait_fetch(12'h00a);
        int_enable <= 3'b100;
        rc_osc_mode <= 1'b0;
        exp_ack.push_back(3'b100);
        for (n = 0; n < 100 && exp_f.size() != 0; n++)
            @(posedge clk_sys);
        chk8(8'(exp_f.size() + exp_ack.size()), 8'h00);
        chk8(8'(ret_cnt), 8'h02);
        tally_and_finish();
    end
endmodule
